// ### common/spsc_map.vh
// Purpose: register map, field positions and reset values of the power-save control block
// Assumes: 32-bit AHB-Lite word per register, narrow data in the low bits
// Notes: included by the power-save control core
`ifndef SPSC_MAP_VH
`define SPSC_MAP_VH
`define SPSC_OFS_CMD 12'h000
`define SPSC_OFS_MODE 12'h004
`define SPSC_OFS_CTRL 12'h008
`define SPSC_OFS_HALT 12'h00C
`define SPSC_OFS_STAT 12'h010
`define SPSC_BIT_NMI_DIS 5
`define SPSC_BIT_IRQ_DIS 4
`define SPSC_BIT_STB 1
`define SPSC_BIT_MODE 0
`define SPSC_CTRL_RST 8'h00
`define SPSC_MODE_RST 8'h00
`define SPSC_CTRL_WMASK 8'h30
`define SPSC_UNDEF_RD 32'h00000000
`endif

// ### core/spsc_core.v
// Purpose: standby and HALT power-save control with write-protected control register
// Assumes: AHB-Lite slave, zero wait states, OKAY only; interrupt inputs are asynchronous pins
// Notes: clock gates are level enables for the clock tree, not gated clocks here
`timescale 1ns/1ps
`include "spsc_map.vh"

module spsc_core #(
  parameter IRQ_W = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire nmi_in,
  input wire [IRQ_W-1:0] external_irq_inputs,
  input wire [IRQ_W-1:0] irq_mask,
  input wire halt_exec,
  output reg cpu_clk_en,
  output reg sys_clk_en,
  output reg periph_clk_en,
  output reg osc_pll_en,
  output reg clkout_en,
  output reg irq_ack_block,
  output reg idle_active,
  output reg stop_active,
  output reg halt_active
);
  localparam ST_RUN = 4'b0001;
  localparam ST_HALT = 4'b0010;
  localparam ST_IDLE = 4'b0100;
  localparam ST_STOP = 4'b1000;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [7:0] ctrl_r;
  reg [7:0] mode_r;
  reg unlock_r;
  reg ph_valid_r;
  reg ph_write_r;
  reg [11:0] ph_addr_r;
  reg nmi_s1_r;
  reg nmi_s2_r;
  reg [IRQ_W-1:0] irq_s1_r;
  reg [IRQ_W-1:0] irq_s2_r;
  reg [31:0] rdata_nxt;

  wire addr_take = hsel && hready && htrans[1];
  wire wr_cmd = ph_valid_r && ph_write_r && (ph_addr_r == `SPSC_OFS_CMD);
  wire wr_ctrl = ph_valid_r && ph_write_r && (ph_addr_r == `SPSC_OFS_CTRL);
  wire wr_mode = ph_valid_r && ph_write_r && (ph_addr_r == `SPSC_OFS_MODE);
  wire ctrl_ok = wr_ctrl && unlock_r;
  wire nmi_wake = nmi_s2_r && !ctrl_r[`SPSC_BIT_NMI_DIS];
  wire irq_wake = (|(irq_s2_r & ~irq_mask)) && !ctrl_r[`SPSC_BIT_IRQ_DIS];
  wire in_standby = state_r[2] | state_r[3];
  wire wake = nmi_wake | irq_wake;

  // word-aligned offset of the transfer in its address phase
  wire [11:0] addr_ofs = {haddr[11:2], 2'b00};
  wire rd_take = addr_take && !hwrite;

  // any unmasked maskable request, before the wake-disable bit is applied
  wire irq_pending = |(irq_s2_r & ~irq_mask);

  // halt ends on any nmi or unmasked request, the disable bits do not apply
  wire halt_wake = nmi_s2_r | irq_pending;

  // only the wake-disable bits and the standby flag are writable
  wire [7:0] ctrl_wdata = (hwdata[7:0] & `SPSC_CTRL_WMASK) | {6'h00, hwdata[`SPSC_BIT_STB], 1'b0};

  // decoded next mode, one bit per state
  wire run_nxt = state_nxt[0];
  wire halt_nxt = state_nxt[1];
  wire idle_nxt = state_nxt[2];
  wire stop_nxt = state_nxt[3];

  // the system clock tree keeps running in run and halt
  wire clk_tree_on = run_nxt | halt_nxt;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_s1_r <= 1'b0;
      nmi_s2_r <= 1'b0;
      irq_s1_r <= {IRQ_W{1'b0}};
      irq_s2_r <= {IRQ_W{1'b0}};
    end else begin
      nmi_s1_r <= nmi_in;
      nmi_s2_r <= nmi_s1_r;
      irq_s1_r <= external_irq_inputs;
      irq_s2_r <= irq_s1_r;
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (ctrl_ok && hwdata[`SPSC_BIT_STB]) begin
          state_nxt = mode_r[`SPSC_BIT_MODE] ? ST_STOP : ST_IDLE;
        end else if (halt_exec) begin
          state_nxt = ST_HALT;
        end
      end
      ST_HALT: begin
        if (halt_wake) begin
          state_nxt = ST_RUN;
        end
      end
      ST_IDLE, ST_STOP: begin
        if (wake) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  // read data is chosen in the address phase so that it stands in the data phase
  always @* begin
    case (addr_ofs)
      `SPSC_OFS_CTRL: rdata_nxt = {24'h000000, ctrl_r};
      `SPSC_OFS_MODE: rdata_nxt = {24'h000000, mode_r};
      `SPSC_OFS_STAT: rdata_nxt = {28'h0000000, state_r};
      `SPSC_OFS_CMD: rdata_nxt = `SPSC_UNDEF_RD;
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_RUN;
      ctrl_r <= `SPSC_CTRL_RST;
      mode_r <= `SPSC_MODE_RST;
      unlock_r <= 1'b0;
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_addr_r <= 12'h000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      cpu_clk_en <= 1'b1;
      sys_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_pll_en <= 1'b1;
      clkout_en <= 1'b1;
      irq_ack_block <= 1'b0;
      idle_active <= 1'b0;
      stop_active <= 1'b0;
      halt_active <= 1'b0;
    end else begin
      ph_valid_r <= addr_take;
      ph_write_r <= hwrite;
      ph_addr_r <= addr_ofs;
      if (rd_take) begin
        hrdata <= rdata_nxt;
      end
      // unlock lasts for exactly the next bus write
      if (wr_cmd) begin
        unlock_r <= 1'b1;
      end else if (ph_valid_r && ph_write_r) begin
        unlock_r <= 1'b0;
      end
      // block acknowledge in the cycle after the address phase and after the data phase of a command store
      irq_ack_block <= (addr_take && hwrite && haddr[11:0] == `SPSC_OFS_CMD) || (wr_cmd && !wr_ctrl);
      if (wr_mode) begin
        mode_r <= {7'h00, hwdata[`SPSC_BIT_MODE]};
      end
      if (ctrl_ok) begin
        ctrl_r <= ctrl_wdata;
      end else if (in_standby && wake) begin
        ctrl_r[`SPSC_BIT_STB] <= 1'b0;
      end
      state_r <= state_nxt;
      // halt gates only the cpu clock, all else runs and state is held
      cpu_clk_en <= run_nxt;
      sys_clk_en <= clk_tree_on;
      periph_clk_en <= clk_tree_on;
      clkout_en <= clk_tree_on;
      // oscillator and pll stop only in software stop
      osc_pll_en <= !stop_nxt;
      halt_active <= halt_nxt;
      idle_active <= idle_nxt;
      stop_active <= stop_nxt;
    end
  end
endmodule

// ### verif/spsc_chk.sv
// Purpose: assertions on the power-save control ports
// Assumes: zero-wait AHB-Lite slave
// Notes: bound to spsc_core
`timescale 1ns/1ps
module spsc_chk (
  input wire hclk, hresetn, hsel, hwrite, hready, halt_exec,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire cpu_clk_en, sys_clk_en, periph_clk_en, osc_pll_en, clkout_en,
  input wire irq_ack_block, idle_active, stop_active, halt_active
);
  wire wr = hsel && hready && htrans[1] && hwrite;
  wire sb = idle_active || stop_active;
  reg armed_r;
  // tracks whether the last taken write hit the command register
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) armed_r <= 1'b0;
    else if (wr) armed_r <= haddr[11:0] == 12'h000;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_HALT_CLK: assert property (halt_active |-> !cpu_clk_en && osc_pll_en)
    else $error("halt clk");
  AST_HALT_PER: assert property (halt_active |-> periph_clk_en && sys_clk_en && clkout_en)
    else $error("halt per");
  AST_HALT_GO: assert property ($rose(halt_exec) && !sb |-> ##[1:3] halt_active)
    else $error("no halt");
  AST_STOP_CLK: assert property (stop_active |-> !osc_pll_en && !cpu_clk_en)
    else $error("stop clk");
  AST_IDLE_CLK: assert property (idle_active |-> osc_pll_en && !sys_clk_en && !cpu_clk_en)
    else $error("idle clk");
  AST_ACK_BLK: assert property (wr && haddr[11:0] == 12'h000 |-> ##[1:2] irq_ack_block)
    else $error("ack");
  AST_ONE_MODE: assert property ($onehot0({idle_active, stop_active, halt_active}))
    else $error("modes");
  AST_REJECT: assert property (wr && haddr[11:0] == 12'h008 && !armed_r && !sb |=> !sb [*3])
    else $error("unprotected");
endmodule
bind spsc_core spsc_chk i_chk (.*);

// ### verif/spsc_tb.sv
// Purpose: self-checking bench for the power-save control block
// Assumes: hready looped from hreadyout
// Notes: one task per scenario
`timescale 1ns/1ps
module testbench;
  reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, nmi_in = 1'b0, halt_exec = 1'b0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  reg [1:0] htrans = 2'h0;
  reg [7:0] external_irq_inputs = 8'h0, irq_mask = 8'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, cpu_clk_en, sys_clk_en, periph_clk_en, osc_pll_en, clkout_en;
  wire irq_ack_block, idle_active, stop_active, halt_active;
  integer n_fail = 0, samples_checked = 0;
  always #20 hclk = ~hclk;
  spsc_core i_dut (.*, .hsize(3'h2), .hready(hreadyout));
  task chk(input [31:0] g, input [31:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input [3:0] a, input w, input [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {28'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    // read data is taken at the edge that ends the data phase
    if (!w) q = hrdata;
  endtask
  task rc(input [3:0] a, input [7:0] e);
    bus(a, 1'b0, 8'h0);
    chk(q, {24'h0, e});
  endtask
  task prot(input [7:0] d);
    bus(4'h0, 1'b1, d);
    bus(4'h8, 1'b1, d);
  endtask
  task wake(input n, input i);
    nmi_in <= n;
    external_irq_inputs <= {7'h0, i};
    repeat (6) @(posedge hclk);
    nmi_in <= 1'b0;
    external_irq_inputs <= 8'h0;
    repeat (3) @(posedge hclk);
  endtask
  task t_reject;
    bus(4'h8, 1'b1, 8'h02);
    bus(4'h0, 1'b1, 8'h5A);
    bus(4'h4, 1'b1, 8'h00);
    bus(4'h8, 1'b1, 8'h02);
    repeat (2) @(posedge hclk);
    chk(cpu_clk_en, 32'h1);
    rc(4'h8, 8'h00);
  endtask
  task t_sb(input m, input [7:0] dis);
    bus(4'h4, 1'b1, {7'h0, m});
    prot(dis);
    prot(dis | 8'h02);
    repeat (5) @(posedge hclk);
    chk({idle_active, stop_active, cpu_clk_en}, {~m, m, 1'b0});
    rc(4'h8, dis | 8'h02);
    wake(dis[5], dis[4]);
    chk(cpu_clk_en, 32'h0);
    wake(dis[4], dis[5]);
    chk(cpu_clk_en, 32'h1);
    rc(4'h8, dis);
  endtask
  task t_halt;
    prot(8'h30);
    halt_exec <= 1'b1;
    @(posedge hclk);
    halt_exec <= 1'b0;
    repeat (3) @(posedge hclk);
    chk({halt_active, cpu_clk_en, periph_clk_en, osc_pll_en, clkout_en}, 32'h17);
    rc(4'h8, 8'h30);
    wake(1'b0, 1'b1);
    chk(halt_active, 32'h0);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rc(4'h8, 8'h00);
    rc(4'h0, 8'h00);
    t_reject;
    t_sb(1'b1, 8'h20);
    t_sb(1'b0, 8'h10);
    t_halt;
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge hclk);
    n_fail = n_fail + 1;
    give_verdict;
  end
endmodule
